//--- rtl/charger_event_flag_bank.sv
// Functional notes
// (RULE1) Port detection status change sets flags b bit 0.
// (RULE2) Data-line detect bit shows detection completed.
// (RULE3) Conversion done flag only in one-shot mode.
// (RULE4) Entering or leaving minimum system regulation sets bit.
// (RULE5) Fast-charge timer expiry rising edge sets bit.
// (RULE6) Trickle timer expiry rising edge sets bit.
// (RULE7) Pre-charge timer expiry rising edge sets bit.
// (RULE8) Top-off timer expiry rising edge sets bit.
// (RULE9) Battery low for OTG sets bit; reserved read zero.
// (RULE10) Cold threshold crossing sets flags d bit 3.
// (RULE11) Cool threshold crossing sets flags d bit 2.
// (RULE12) Warm threshold crossing sets flags d bit 1.
// (RULE13) Hot threshold crossing sets flags d bit 0.
// (RULE14) Entering or leaving charge-current regulation sets bit.
// (RULE15) Entering input bus overvoltage sets bit.
// (RULE16) Entering battery overvoltage sets bit.
// (RULE17) Entering input bus overcurrent sets bit.
// (RULE18) Entering discharge overcurrent sets bit.
// (RULE19) Entering converter overcurrent sets bit.
// (RULE20) Second and first input overvoltage set bits 1, 0.
// (RULE21) Flag registers read-only, zero after reset.
// (RULE22) Unmasked newly set flag pulses the interrupt.
// (RULE23) Flags hold until read, then clear; the data-line done bit also clears when detection restarts.
// (RULE24) Events are edges of synchronised status levels.
`timescale 1ns/100ps
module charger_event_flag_bank (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic                      clk_en,
  input  wire charger_flag_pkg::status_t sts,
  input  wire logic                      adc_one_shot,
  input  wire charger_flag_pkg::reg_req_t req,
  output logic [7:0]                     rd_data,
  output logic                           int_pulse
);

  // ****************************************************************************
  // State: every flip-flop of the bank lives in one record.
  // ****************************************************************************
  typedef struct packed {
    charger_flag_pkg::status_t sync1;   // First synchroniser stage.
    charger_flag_pkg::status_t sync2;   // Second synchroniser stage.
    charger_flag_pkg::status_t prev;    // Previous synchronised sample, for edges.
    logic                      flag_b;  // Held flag of flags b.
    logic [7:0]                flags_c; // Held flags c.
    logic [7:0]                flags_d; // Held flags d.
    logic [7:0]                flags_a; // Held fault flags a.
    logic                      mask_b;  // Mask for flags b bit 0.
    logic [7:0]                mask_c;  // Mask for flags c.
    logic [7:0]                mask_d;  // Mask for flags d.
    logic [7:0]                mask_a;  // Mask for fault flags a.
    logic [7:0]                rdata;   // Registered read answer.
    logic                      irq;     // Registered interrupt pulse.
  } state_t;

  state_t s_q;                          // Current state.
  state_t s_d;                          // Next state.
  charger_flag_pkg::status_t rise;      // Rising edges of synchronised status.
  charger_flag_pkg::status_t chg;       // Any change of synchronised status.
  logic       ev_b;                     // Events for flags b.
  logic [7:0] ev_c;                     // Events for flags c.
  logic [7:0] ev_d;                     // Events for flags d.
  logic [7:0] ev_a;                     // Events for fault flags a.
  logic       rd_b;                     // Read of flags b this cycle.
  logic       rd_c;                     // Read of flags c this cycle.
  logic       rd_d;                     // Read of flags d this cycle.
  logic       rd_a;                     // Read of fault flags a this cycle.

  // ****************************************************************************
  // Edge detection on the second synchroniser stage only.
  // ****************************************************************************
  // The first stage is never looked at, so a level that changes near an edge
  // produces one clean event rather than two.
  always_comb begin
    rise = s_q.sync2 & ~s_q.prev;       // RULE24
    chg  = s_q.sync2 ^ s_q.prev;        // RULE24
  end

  // ****************************************************************************
  // Event vectors laid out as the register bits.
  // ****************************************************************************
  always_comb begin
    ev_b = chg.port_detect_status;                                      // RULE1
    ev_c = 8'h00;
    ev_c[charger_flag_pkg::BIT_DATA_LINE]   = rise.data_line_detect_done; // RULE2
    // A conversion in continuous mode completes constantly and is not flagged.
    ev_c[charger_flag_pkg::BIT_ADC_DONE]    = rise.adc_conv_done & adc_one_shot; // RULE3
    ev_c[charger_flag_pkg::BIT_MIN_SYS]     = chg.min_system_regulation;  // RULE4
    ev_c[charger_flag_pkg::BIT_FAST_TMR]    = rise.fast_charge_expired;   // RULE5
    ev_c[charger_flag_pkg::BIT_TRICKLE_TMR] = rise.trickle_expired;       // RULE6
    ev_c[charger_flag_pkg::BIT_PRECHG_TMR]  = rise.precharge_expired;     // RULE7
    ev_c[charger_flag_pkg::BIT_TOPOFF_TMR]  = rise.topoff_expired;        // RULE8
    ev_d = 8'h00;
    ev_d[charger_flag_pkg::BIT_OTG_LOW]     = rise.battery_below_otg;     // RULE9
    ev_d[charger_flag_pkg::BIT_COLD]        = chg.therm_beyond_cold;      // RULE10
    ev_d[charger_flag_pkg::BIT_COOL]        = chg.therm_beyond_cool;      // RULE11
    ev_d[charger_flag_pkg::BIT_WARM]        = chg.therm_beyond_warm;      // RULE12
    ev_d[charger_flag_pkg::BIT_HOT]         = chg.therm_beyond_hot;       // RULE13
    ev_a = 8'h00;
    ev_a[charger_flag_pkg::BIT_IBAT_REG]    = chg.battery_current_regulation; // RULE14
    ev_a[charger_flag_pkg::BIT_BUS_OVP]     = rise.input_bus_ovp;         // RULE15
    ev_a[charger_flag_pkg::BIT_BAT_OVP]     = rise.battery_ovp;           // RULE16
    ev_a[charger_flag_pkg::BIT_BUS_OCP]     = rise.input_bus_ocp;         // RULE17
    ev_a[charger_flag_pkg::BIT_BAT_OCP]     = rise.battery_discharge_ocp; // RULE18
    ev_a[charger_flag_pkg::BIT_CONV_OCP]    = rise.converter_ocp;         // RULE19
    ev_a[charger_flag_pkg::BIT_IN2_OVP]     = rise.second_input_ovp;      // RULE20
    ev_a[charger_flag_pkg::BIT_IN1_OVP]     = rise.first_input_ovp;       // RULE20
  end

  // ****************************************************************************
  // Read decode.
  // ****************************************************************************
  always_comb begin
    rd_b = req.rd_en && (req.addr == charger_flag_pkg::ADDR_FLAGS_B);
    rd_c = req.rd_en && (req.addr == charger_flag_pkg::ADDR_FLAGS_C);
    rd_d = req.rd_en && (req.addr == charger_flag_pkg::ADDR_FLAGS_D);
    rd_a = req.rd_en && (req.addr == charger_flag_pkg::ADDR_FAULT_A);
  end

  // ****************************************************************************
  // Next-state logic.
  // ****************************************************************************
  // A read returns the flags as they stood, then clears them; an event in the
  // same cycle still sets its bit, so nothing is lost between two reads.
  always_comb begin
    s_d       = s_q;
    s_d.sync1 = sts;                    // RULE24
    s_d.sync2 = s_q.sync1;              // RULE24
    s_d.prev  = s_q.sync2;              // RULE24
    s_d.flag_b  = (s_q.flag_b & ~rd_b) | ev_b;                              // RULE23
    s_d.flags_c = ((s_q.flags_c & {8{~rd_c}}) | ev_c) & charger_flag_pkg::USED_C; // RULE23
    s_d.flags_d = ((s_q.flags_d & {8{~rd_d}}) | ev_d) & charger_flag_pkg::USED_D; // RULE9
    s_d.flags_a = ((s_q.flags_a & {8{~rd_a}}) | ev_a) & charger_flag_pkg::USED_A; // RULE23
    // Detection restarting drops the done bit, unless it completes again now.
    if (!s_q.sync2.data_line_detect_done && !ev_c[charger_flag_pkg::BIT_DATA_LINE]) begin
      s_d.flags_c[charger_flag_pkg::BIT_DATA_LINE] = 1'b0;                  // RULE2
    end
    // Only mask registers take writes; flag offsets ignore them.
    if (req.wr_en) begin                                                    // RULE21
      case (req.addr)
        charger_flag_pkg::ADDR_MASK_B: begin
          s_d.mask_b = req.wdata[charger_flag_pkg::BIT_PORT_DETECT];
        end
        charger_flag_pkg::ADDR_MASK_C: begin
          s_d.mask_c = req.wdata & charger_flag_pkg::USED_C;
        end
        charger_flag_pkg::ADDR_MASK_D: begin
          s_d.mask_d = req.wdata & charger_flag_pkg::USED_D;
        end
        charger_flag_pkg::ADDR_MASK_A: begin
          s_d.mask_a = req.wdata & charger_flag_pkg::USED_A;
        end
        default: begin
        end
      endcase
    end
    // Read answer, reserved bits zero, unmapped offsets zero.
    if (req.rd_en) begin
      case (req.addr)
        charger_flag_pkg::ADDR_FLAGS_B: s_d.rdata = {7'h00, s_q.flag_b};
        charger_flag_pkg::ADDR_FLAGS_C: s_d.rdata = s_q.flags_c;
        charger_flag_pkg::ADDR_FLAGS_D: s_d.rdata = s_q.flags_d;            // RULE9
        charger_flag_pkg::ADDR_FAULT_A: s_d.rdata = s_q.flags_a;
        charger_flag_pkg::ADDR_MASK_B:  s_d.rdata = {7'h00, s_q.mask_b};
        charger_flag_pkg::ADDR_MASK_C:  s_d.rdata = s_q.mask_c;
        charger_flag_pkg::ADDR_MASK_D:  s_d.rdata = s_q.mask_d;
        charger_flag_pkg::ADDR_MASK_A:  s_d.rdata = s_q.mask_a;
        default:                        s_d.rdata = charger_flag_pkg::READ_ZERO;
      endcase
    end
    // A pulse for each cycle that brings a new unmasked event.
    s_d.irq = (ev_b & ~s_q.mask_b) | (|(ev_c & ~s_q.mask_c)) |
              (|(ev_d & ~s_q.mask_d)) | (|(ev_a & ~s_q.mask_a));            // RULE22
  end

  // ****************************************************************************
  // State register with clock enable.
  // ****************************************************************************
  // Everything resets to zero, flags and masks alike.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;                        // RULE21
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign rd_data   = s_q.rdata;
  assign int_pulse = s_q.irq;

  // ****************************************************************************
  // Assertions.
  // ****************************************************************************
  property p_port_detect;
    @(posedge mclk) disable iff (!rst_n)
      clk_en && (s_q.sync2.port_detect_status != s_q.prev.port_detect_status) |=> s_q.flag_b;
  endproperty
  a_port_detect: assert property (p_port_detect) else $error("port detect change not flagged"); // RULE1

  property p_dpdm_clear;
    @(posedge mclk) disable iff (!rst_n)
      clk_en && !s_q.sync2.data_line_detect_done && !s_q.sync1.data_line_detect_done
      ##1 clk_en |=> !s_q.flags_c[charger_flag_pkg::BIT_DATA_LINE];
  endproperty
  a_dpdm_clear: assert property (p_dpdm_clear) else $error("data-line done bit set while running"); // RULE2

  property p_adc_continuous;
    @(posedge mclk) disable iff (!rst_n)
      clk_en && !adc_one_shot && !s_q.flags_c[charger_flag_pkg::BIT_ADC_DONE]
      |=> !s_q.flags_c[charger_flag_pkg::BIT_ADC_DONE];
  endproperty
  a_adc_continuous: assert property (p_adc_continuous) else $error("conversion flagged outside one-shot"); // RULE3

  property p_fast_timer;
    @(posedge mclk) disable iff (!rst_n)
      clk_en && $rose(s_q.sync2.fast_charge_expired) |=> s_q.flags_c[charger_flag_pkg::BIT_FAST_TMR];
  endproperty
  a_fast_timer: assert property (p_fast_timer) else $error("fast-charge expiry not flagged"); // RULE5

  property p_reserved_d;
    @(posedge mclk) disable iff (!rst_n)
      clk_en && rd_d |=> (rd_data[7:5] == 3'h0) && (rd_data[4:0] == $past(s_q.flags_d[4:0]));
  endproperty
  a_reserved_d: assert property (p_reserved_d) else $error("flags d read wrong"); // RULE9

  property p_cold;
    @(posedge mclk) disable iff (!rst_n)
      clk_en && (s_q.sync2.therm_beyond_cold ^ s_q.prev.therm_beyond_cold)
      |=> s_q.flags_d[charger_flag_pkg::BIT_COLD];
  endproperty
  a_cold: assert property (p_cold) else $error("cold crossing not flagged"); // RULE10

  property p_read_clears;
    @(posedge mclk) disable iff (!rst_n)
      clk_en && rd_a && (ev_a == 8'h00) |=> (s_q.flags_a == 8'h00);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("fault flags not cleared by read"); // RULE23

  property p_write_ignored;
    @(posedge mclk) disable iff (!rst_n)
      clk_en && req.wr_en && !req.rd_en && (req.addr == charger_flag_pkg::ADDR_FAULT_A) && (ev_a == 8'h00)
      |=> s_q.flags_a == $past(s_q.flags_a);
  endproperty
  a_write_ignored: assert property (p_write_ignored) else $error("write changed fault flags"); // RULE21

  property p_irq;
    @(posedge mclk) disable iff (!rst_n)
      clk_en && (|(ev_a & ~s_q.mask_a)) |=> int_pulse;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked fault gave no pulse"); // RULE22

  property p_sync_latency;
    @(posedge mclk) disable iff (!rst_n)
      ($past(clk_en) && clk_en && $rose(sts.topoff_expired)) ##1 clk_en ##1 clk_en
      |=> s_q.flags_c[charger_flag_pkg::BIT_TOPOFF_TMR];
  endproperty
  a_sync_latency: assert property (p_sync_latency) else $error("top-off expiry missed"); // RULE24

  c_port_flag: cover property (@(posedge mclk) disable iff (!rst_n) $rose(s_q.flag_b));
  c_irq:       cover property (@(posedge mclk) disable iff (!rst_n) int_pulse);
  c_read_a:    cover property (@(posedge mclk) disable iff (!rst_n) rd_a && (s_q.flags_a != 8'h00));

endmodule : charger_event_flag_bank

//--- rtl/charger_flag_pkg.sv
// ****************************************************************************
// Shared constants and carriers for the charger event flag bank.
// ****************************************************************************
package charger_flag_pkg;

  // ****************************************************************************
  // Register offsets on the serial register port.
  // ****************************************************************************
  localparam logic [7:0] ADDR_FLAGS_B = 8'h23;  // Charger event flags b, bit 0 held here.
  localparam logic [7:0] ADDR_FLAGS_C = 8'h24;  // Charger event flags c.
  localparam logic [7:0] ADDR_FLAGS_D = 8'h25;  // Charger event flags d.
  localparam logic [7:0] ADDR_FAULT_A = 8'h26;  // Fault event flags a.
  localparam logic [7:0] ADDR_MASK_B  = 8'h29;  // Mask for flags b, bit 0 held here.
  localparam logic [7:0] ADDR_MASK_C  = 8'h2A;  // Mask for flags c.
  localparam logic [7:0] ADDR_MASK_D  = 8'h2B;  // Mask for flags d.
  localparam logic [7:0] ADDR_MASK_A  = 8'h2C;  // Mask for fault flags a.

  // ****************************************************************************
  // Reset values and field layouts.
  // ****************************************************************************
  localparam logic [7:0] FLAGS_RESET = 8'h00;   // Every flag and mask clears at power-on.
  localparam logic [7:0] READ_ZERO   = 8'h00;   // Answer to an unmapped address.
  localparam logic [7:0] USED_C      = 8'h7F;   // Bit 7 of flags c is reserved.
  localparam logic [7:0] USED_D      = 8'h1F;   // Bits 7 to 5 of flags d are reserved.
  localparam logic [7:0] USED_A      = 8'hFF;   // Every bit of fault flags a is used.

  localparam int BIT_PORT_DETECT  = 0;          // Flags b: port detection changed.
  localparam int BIT_DATA_LINE    = 6;          // Flags c: data-line detection complete.
  localparam int BIT_ADC_DONE     = 5;          // Flags c: one-shot conversion done.
  localparam int BIT_MIN_SYS      = 4;          // Flags c: minimum system regulation.
  localparam int BIT_FAST_TMR     = 3;          // Flags c: fast-charge timer.
  localparam int BIT_TRICKLE_TMR  = 2;          // Flags c: trickle timer.
  localparam int BIT_PRECHG_TMR   = 1;          // Flags c: pre-charge timer.
  localparam int BIT_TOPOFF_TMR   = 0;          // Flags c: top-off timer.
  localparam int BIT_OTG_LOW      = 4;          // Flags d: battery low for OTG.
  localparam int BIT_COLD         = 3;          // Flags d: cold threshold crossed.
  localparam int BIT_COOL         = 2;          // Flags d: cool threshold crossed.
  localparam int BIT_WARM         = 1;          // Flags d: warm threshold crossed.
  localparam int BIT_HOT          = 0;          // Flags d: hot threshold crossed.
  localparam int BIT_IBAT_REG     = 7;          // Fault a: charge-current regulation.
  localparam int BIT_BUS_OVP      = 6;          // Fault a: input bus overvoltage.
  localparam int BIT_BAT_OVP      = 5;          // Fault a: battery overvoltage.
  localparam int BIT_BUS_OCP      = 4;          // Fault a: input bus overcurrent.
  localparam int BIT_BAT_OCP      = 3;          // Fault a: discharge overcurrent.
  localparam int BIT_CONV_OCP     = 2;          // Fault a: converter overcurrent.
  localparam int BIT_IN2_OVP      = 1;          // Fault a: second input overvoltage.
  localparam int BIT_IN1_OVP      = 0;          // Fault a: first input overvoltage.

  // ****************************************************************************
  // Status levels from the charger core, one bit each.
  // ****************************************************************************
  typedef struct packed {
    logic port_detect_status;           // Standard port detection status.
    logic data_line_detect_done;        // Data-line detection has completed.
    logic adc_conv_done;                // Converter finished a conversion.
    logic min_system_regulation;        // Regulating at minimum system voltage.
    logic fast_charge_expired;          // Fast-charge safety timer expired.
    logic trickle_expired;              // Trickle timer expired.
    logic precharge_expired;            // Pre-charge timer expired.
    logic topoff_expired;               // Top-off timer expired.
    logic battery_below_otg;            // Battery below the OTG enable level.
    logic therm_beyond_cold;            // Thermistor past the cold threshold.
    logic therm_beyond_cool;            // Thermistor past the cool threshold.
    logic therm_beyond_warm;            // Thermistor past the warm threshold.
    logic therm_beyond_hot;             // Thermistor past the hot threshold.
    logic battery_current_regulation;   // In charge-current regulation.
    logic input_bus_ovp;                // Input bus overvoltage protection.
    logic battery_ovp;                  // Battery overvoltage protection.
    logic input_bus_ocp;                // Input bus overcurrent protection.
    logic battery_discharge_ocp;        // Battery discharge overcurrent protection.
    logic converter_ocp;                // Converter switch overcurrent protection.
    logic second_input_ovp;             // Second adapter input overvoltage.
    logic first_input_ovp;              // First adapter input overvoltage.
  } status_t;

  // ****************************************************************************
  // Register access strobes from the serial register engine.
  // ****************************************************************************
  typedef struct packed {
    logic       rd_en;                  // One-cycle read strobe.
    logic       wr_en;                  // One-cycle write strobe.
    logic [7:0] addr;                   // Register offset.
    logic [7:0] wdata;                  // Write data.
  } reg_req_t;

endpackage : charger_flag_pkg

//--- tb/reg_host_model.sv
`timescale 1ns/100ps
// ****************************************************************************
// Host side of the register port: one-cycle strobes, reads counted for the bench.
// ****************************************************************************
module reg_host_model (
  input  wire logic                  mclk,
  output charger_flag_pkg::reg_req_t req
);
  int rd_done;  // Completed reads, watched by the bench monitor.

  // Strobes start idle so nothing is taken during reset.
  initial begin
    req     = '0;
    rd_done = 0;
  end

  // One access: raise just after an edge, hold through the taking edge, then release.
  // The address is inverted on release so a stale value is never mistaken for a live one.
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata);
    @(posedge mclk);
    #1;
    req.rd_en = !wr;
    req.wr_en = wr;
    req.addr  = addr;
    req.wdata = wdata;
    @(posedge mclk);
    #1;
    req.rd_en = 1'b0;
    req.wr_en = 1'b0;
    req.addr  = ~addr;
    req.wdata = ~wdata;
    if (!wr) begin
      rd_done = rd_done + 1;
    end
  endtask : access
endmodule : reg_host_model

//--- tb/test_charger_event_flag_bank.sv
`timescale 1ns/100ps
module test_charger_event_flag_bank;
  // ****************************************************************************
  // Signals and bookkeeping.
  // ****************************************************************************
  logic                       mclk;
  logic                       rst_n;
  logic                       clk_en;      // Bench-driven clock enable, lowered once to freeze the bank.
  logic                       adc_one_shot;
  charger_flag_pkg::status_t  sts;
  charger_flag_pkg::reg_req_t req;
  logic [7:0]                 rd_data;
  logic                       int_pulse;
  logic [7:0]                 exp_q[$];    // Expected read answers, oldest first.
  logic [7:0]                 a;           // Register under test.
  logic [7:0]                 b;           // Expected flag bit.
  logic [7:0]                 mval;        // Random mask value.
  logic                       chg;         // Flag set on both edges.
  int                         num_errors;
  int                         cmp_count;
  int                         int_count;   // Interrupt pulses seen.
  int                         n;
  int                         seen;
  int                         cycles;

  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  charger_event_flag_bank uut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .sts(sts),
                               .adc_one_shot(adc_one_shot), .req(req), .rd_data(rd_data), .int_pulse(int_pulse));
  reg_host_model host (.mclk(mclk), .req(req));

  // ****************************************************************************
  // Compare, verdict and access tasks.
  // ****************************************************************************
  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : check8

  task automatic end_of_test();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // A read notes its expectation first; the monitor compares when the answer lands.
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    exp_q.push_back(exp);
    host.access(1'b0, addr, 8'h00);
  endtask : rd

  // Status levels move just after an edge, then settle through the synchroniser.
  task automatic set_sts(input int i, input logic v);
    @(posedge mclk);
    #1;
    sts[i] = v;
    repeat (5) @(posedge mclk);
  endtask : set_sts

  // ****************************************************************************
  // Monitors: read answers, interrupt pulses and the hang limit.
  // ****************************************************************************
  always @(posedge mclk) begin
    if (host.rd_done != seen) begin
      seen = seen + 1;
      check8("rd_data", exp_q.pop_front(), rd_data);
    end
    if (int_pulse === 1'b1) begin
      int_count = int_count + 1;
    end
    cycles = cycles + 1;
    if (cycles == 5000) begin
      num_errors = num_errors + 1;
      end_of_test();
    end
  end

  // ****************************************************************************
  // Main sequence.
  // ****************************************************************************
  initial begin
    {num_errors, cmp_count, int_count, seen, cycles} = '0;
    rst_n        = 1'b0;
    clk_en       = 1'b1;
    adc_one_shot = 1'b0;
    sts          = '0;
    void'($urandom(57024));
    repeat (6) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    // Every flag, mask and two unmapped places read zero out of reset.
    for (int i = 0; i < 10; i++) begin
      rd(8'h23 + i[7:0] + ((i > 3) ? 8'h02 : 8'h00), 8'h00);
    end
    host.access(1'b1, 8'h26, 8'hFF);
    rd(8'h26, 8'h00);
    mval = 8'($urandom);
    host.access(1'b1, 8'h2B, mval);
    rd(8'h2B, mval & charger_flag_pkg::USED_D);
    host.access(1'b1, 8'h2B, 8'h00);
    // Conversion done outside one-shot mode leaves the flag clear.
    set_sts(18, 1'b1);
    rd(8'h24, 8'h00);
    set_sts(18, 1'b0);
    #1;
    adc_one_shot = 1'b1;
    // Walk every status level up and down; the table maps it to its flag.
    for (int k = 0; k < 21; k++) begin
      a   = (k == 0) ? 8'h23 : (k < 8) ? 8'h24 : (k < 13) ? 8'h25 : 8'h26;
      b   = 8'h01 << ((k == 0) ? 0 : (k < 8) ? 7 - k : (k < 13) ? 12 - k : 20 - k);
      chg = (k == 0) || (k == 3) || (k >= 9 && k <= 13);
      n   = int_count;
      set_sts(20 - k, 1'b1);
      rd(a, b);
      rd(a, 8'h00);
      check8("int_pulse count", n[7:0] + 8'h01, int_count[7:0]);
      set_sts(20 - k, 1'b0);
      rd(a, chg ? b : 8'h00);
    end
    // A masked event still latches but raises no pulse.
    host.access(1'b1, 8'h2C, 8'h40);
    n = int_count;
    set_sts(6, 1'b1);
    rd(8'h26, 8'h40);
    check8("masked int_pulse count", n[7:0], int_count[7:0]);
    // A low clock enable freezes the bank: the read is not taken and the
    // answer of the last read stands; the event waits until the thaw.
    n = int_count;
    @(posedge mclk);
    #1;
    clk_en = 1'b0;
    set_sts(5, 1'b1);
    rd(8'h26, 8'h40);
    check8("frozen int_pulse count", n[7:0], int_count[7:0]);
    clk_en = 1'b1;
    repeat (5) @(posedge mclk);
    rd(8'h26, 8'h20);
    check8("thawed int_pulse count", n[7:0] + 8'h01, int_count[7:0]);
    repeat (3) @(posedge mclk);
    end_of_test();
  end
endmodule : test_charger_event_flag_bank
